// *** logic/segtd_consts.svh ***
// Purpose: named constants for the segment type decode and check block
// Assumes: APB byte addresses, one 32-bit word per register
// Notes: type bit indices count from bit 8 of the descriptor's upper word
`ifndef SEGTD_CONSTS_SVH
`define SEGTD_CONSTS_SVH

// Register byte offsets
`define SEGTD_CTRL_OFS 12'h000
`define SEGTD_STAT_OFS 12'h004
`define SEGTD_FCNT_OFS 12'h008

// Control register fields and reset value
`define SEGTD_CTRL_PROT 0
`define SEGTD_CTRL_ABIT 1
`define SEGTD_CTRL_RST 2'h3

// Type field bit positions (descriptor bits 8..11)
`define SEGTD_T_ACC 0
`define SEGTD_T_WR 1
`define SEGTD_T_RD 1
`define SEGTD_T_EXP 2
`define SEGTD_T_CONF 2
`define SEGTD_T_CODE 3

// System type codes
`define SEGTD_SYS_TSS16_AV 4'h1
`define SEGTD_SYS_LDT 4'h2
`define SEGTD_SYS_TSS16_BSY 4'h3
`define SEGTD_SYS_CALL16 4'h4
`define SEGTD_SYS_TASKGATE 4'h5
`define SEGTD_SYS_INT16 4'h6
`define SEGTD_SYS_TRAP16 4'h7
`define SEGTD_SYS_TSS32_AV 4'h9
`define SEGTD_SYS_TSS32_BSY 4'hB
`define SEGTD_SYS_CALL32 4'hC
`define SEGTD_SYS_INT32 4'hE
`define SEGTD_SYS_TRAP32 4'hF

// Limit scaling and bounds
`define SEGTD_PAGE_FILL 12'hFFF
`define SEGTD_LIM_PAD 12'h000
`define SEGTD_SMALL_TOP 32'h0000FFFF

// Status register field positions and fault counter width
`define SEGTD_ST_FAULT 0
`define SEGTD_ST_CAUSE 4
`define SEGTD_ST_CLASS 8
`define SEGTD_ST_SYS 12
`define SEGTD_ST_CPL 16
`define SEGTD_FCNT_W 16

`endif

// *** logic/segtd_pkg.sv ***
// Purpose: types shared by the segment type decode and check block
// Assumes: nothing beyond SystemVerilog enums
// Notes: encodings follow declaration order, starting from zero
package segtd_pkg;

  typedef enum logic [2:0] {
    SEGTD_OP_LOAD_DATA,
    SEGTD_OP_LOAD_STACK,
    SEGTD_OP_XFER_CODE,
    SEGTD_OP_READ,
    SEGTD_OP_WRITE,
    SEGTD_OP_FETCH
  } segtd_op_t;

  typedef enum logic [1:0] {
    SEGTD_CL_DATA,
    SEGTD_CL_CODE,
    SEGTD_CL_SYSSEG,
    SEGTD_CL_GATE
  } segtd_class_t;

  typedef enum logic [3:0] {
    SEGTD_SK_NONE,
    SEGTD_SK_TSS16_AV,
    SEGTD_SK_LDT,
    SEGTD_SK_TSS16_BSY,
    SEGTD_SK_CALL16,
    SEGTD_SK_TASKGATE,
    SEGTD_SK_INT16,
    SEGTD_SK_TRAP16,
    SEGTD_SK_TSS32_AV,
    SEGTD_SK_TSS32_BSY,
    SEGTD_SK_CALL32,
    SEGTD_SK_INT32,
    SEGTD_SK_TRAP32,
    SEGTD_SK_RESERVED
  } segtd_sys_t;

  typedef enum logic [3:0] {
    SEGTD_FC_NONE,
    SEGTD_FC_WRITE,
    SEGTD_FC_STACK,
    SEGTD_FC_LIMIT,
    SEGTD_FC_PRIV,
    SEGTD_FC_EXEC_ONLY,
    SEGTD_FC_NOT_CODE,
    SEGTD_FC_SYS_USE,
    SEGTD_FC_RESERVED
  } segtd_cause_t;

endpackage

// *** logic/segtd_check.sv ***
// Purpose: decode a descriptor type field and apply segment access checks
// Assumes: core inputs are synchronous to CORE_CLK_I and stable with CHK_VALID_I
// Notes: one check per cycle, result one cycle after the request
//
// Register access over APB and the address map were decided locally.
`timescale 1ns/10ps
`include "segtd_consts.svh"

module segtd_check
  import segtd_pkg::*;
(
  // Clock and reset
  input wire logic CORE_CLK_I,
  input wire logic RST_N_I,
  // APB slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // Check request from the core
  input wire logic CHK_VALID_I,
  input wire segtd_op_t CHK_OP_I,
  input wire logic DESC_CLASS_I,
  input wire logic [3:0] DESC_TYPE_I,
  input wire logic [1:0] DESC_DPL_I,
  input wire logic DESC_BIG_I,
  input wire logic DESC_GRAN_I,
  input wire logic [19:0] DESC_LIMIT_I,
  input wire logic [31:0] ACC_OFFSET_I,
  input wire logic [1:0] CUR_CPL_I,
  input wire logic VIA_GATE_I,
  // Check result
  output logic RES_VALID_O,
  output logic PROTECTION_FAULT_O,
  output segtd_cause_t FAULT_CAUSE_O,
  output segtd_class_t SEG_CLASS_O,
  output segtd_sys_t SYS_KIND_O,
  output logic SYS_INVALID_O,
  output logic READABLE_O,
  output logic WRITABLE_O,
  output logic EXPAND_DOWN_O,
  output logic CONFORMING_O,
  output logic [1:0] NEW_CPL_O,
  // Type field write-back
  output logic TYPE_WB_VALID_O,
  output logic [3:0] TYPE_WB_O
);

  ////////////////////////////////////////////////////////////////////////
  // Decode

  logic is_app;
  logic is_code;
  logic acc_flag;
  logic wr_en;
  logic rd_en;
  logic exp_down;
  logic conf;
  segtd_class_t cls;
  segtd_sys_t sys_kind;
  logic sys_bad;

  assign is_app = DESC_CLASS_I;
  assign is_code = is_app & DESC_TYPE_I[`SEGTD_T_CODE];
  assign acc_flag = is_app & DESC_TYPE_I[`SEGTD_T_ACC];
  assign wr_en = is_app & ~is_code & DESC_TYPE_I[`SEGTD_T_WR];
  assign exp_down = is_app & ~is_code & DESC_TYPE_I[`SEGTD_T_EXP];
  assign rd_en = is_app & (~is_code | DESC_TYPE_I[`SEGTD_T_RD]);
  assign conf = is_code & DESC_TYPE_I[`SEGTD_T_CONF];

  // System type table
  always_comb begin
    sys_kind = SEGTD_SK_NONE;
    if (!is_app) begin
      case (DESC_TYPE_I)
        `SEGTD_SYS_TSS16_AV: sys_kind = SEGTD_SK_TSS16_AV;
        `SEGTD_SYS_LDT: sys_kind = SEGTD_SK_LDT;
        `SEGTD_SYS_TSS16_BSY: sys_kind = SEGTD_SK_TSS16_BSY;
        `SEGTD_SYS_CALL16: sys_kind = SEGTD_SK_CALL16;
        `SEGTD_SYS_TASKGATE: sys_kind = SEGTD_SK_TASKGATE;
        `SEGTD_SYS_INT16: sys_kind = SEGTD_SK_INT16;
        `SEGTD_SYS_TRAP16: sys_kind = SEGTD_SK_TRAP16;
        `SEGTD_SYS_TSS32_AV: sys_kind = SEGTD_SK_TSS32_AV;
        `SEGTD_SYS_TSS32_BSY: sys_kind = SEGTD_SK_TSS32_BSY;
        `SEGTD_SYS_CALL32: sys_kind = SEGTD_SK_CALL32;
        `SEGTD_SYS_INT32: sys_kind = SEGTD_SK_INT32;
        `SEGTD_SYS_TRAP32: sys_kind = SEGTD_SK_TRAP32;
        default: sys_kind = SEGTD_SK_RESERVED;
      endcase
    end
  end

  assign sys_bad = (sys_kind == SEGTD_SK_RESERVED);

  // Class grouping
  always_comb begin
    case (sys_kind)
      SEGTD_SK_NONE: cls = is_code ? SEGTD_CL_CODE : SEGTD_CL_DATA;
      SEGTD_SK_TSS16_AV,
      SEGTD_SK_TSS16_BSY,
      SEGTD_SK_TSS32_AV,
      SEGTD_SK_TSS32_BSY,
      SEGTD_SK_LDT,
      SEGTD_SK_RESERVED: cls = SEGTD_CL_SYSSEG;
      default: cls = SEGTD_CL_GATE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Limit check
  // With the granularity flag set the low twelve offset bits are tested only for expand-down segments

  logic [31:0] eff_limit;
  logic [31:0] top_bound;
  logic lim_fault;

  always_comb begin
    if (DESC_GRAN_I) begin
      eff_limit = {DESC_LIMIT_I, `SEGTD_PAGE_FILL};
    end else begin
      eff_limit = {`SEGTD_LIM_PAD, DESC_LIMIT_I};
    end
    top_bound = DESC_BIG_I ? '1 : `SEGTD_SMALL_TOP;
    if (exp_down) begin
      // Smaller limit opens more room at the bottom
      lim_fault = (ACC_OFFSET_I < eff_limit) | (ACC_OFFSET_I > top_bound);
    end else begin
      lim_fault = (ACC_OFFSET_I > eff_limit);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Access rules

  logic [1:0] ctrl_reg;
  logic prot_on;
  logic fault_c;
  segtd_cause_t cause_c;
  logic [1:0] cpl_c;
  logic is_load;
  logic is_access;

  assign prot_on = ctrl_reg[`SEGTD_CTRL_PROT];
  assign is_load = (CHK_OP_I == SEGTD_OP_LOAD_DATA) |
                   (CHK_OP_I == SEGTD_OP_LOAD_STACK) |
                   (CHK_OP_I == SEGTD_OP_XFER_CODE);
  assign is_access = ~is_load;

  always_comb begin
    cause_c = SEGTD_FC_NONE;
    cpl_c = CUR_CPL_I;
    if (sys_bad) begin
      cause_c = SEGTD_FC_RESERVED;
    end else if (!is_app) begin
      cause_c = SEGTD_FC_SYS_USE;
    end else begin
      case (CHK_OP_I)
        SEGTD_OP_LOAD_DATA: begin
          if (is_code && !rd_en) begin
            cause_c = SEGTD_FC_EXEC_ONLY;
          end else if (!conf && DESC_DPL_I > CUR_CPL_I) begin
            // Same or less privileged code may load it; a more privileged
            // caller reaching a less privileged non-conforming segment faults
            cause_c = SEGTD_FC_PRIV;
          end
        end
        SEGTD_OP_LOAD_STACK: begin
          if (!wr_en) begin
            cause_c = SEGTD_FC_STACK;
          end else if (DESC_DPL_I != CUR_CPL_I) begin
            cause_c = SEGTD_FC_PRIV;
          end
        end
        SEGTD_OP_XFER_CODE: begin
          if (!is_code) begin
            cause_c = SEGTD_FC_NOT_CODE;
          end else if (conf) begin
            if (DESC_DPL_I > CUR_CPL_I) begin
              cause_c = SEGTD_FC_PRIV;
            end else begin
              cpl_c = CUR_CPL_I;
            end
          end else if (DESC_DPL_I != CUR_CPL_I) begin
            if (VIA_GATE_I) begin
              cpl_c = DESC_DPL_I;
            end else begin
              cause_c = SEGTD_FC_PRIV;
            end
          end
        end
        SEGTD_OP_READ: begin
          if (!rd_en) begin
            cause_c = SEGTD_FC_EXEC_ONLY;
          end else if (lim_fault) begin
            cause_c = SEGTD_FC_LIMIT;
          end
        end
        SEGTD_OP_WRITE: begin
          if (is_code && prot_on) begin
            cause_c = SEGTD_FC_WRITE;
          end else if (!is_code && !wr_en) begin
            cause_c = SEGTD_FC_WRITE;
          end else if (lim_fault) begin
            cause_c = SEGTD_FC_LIMIT;
          end
        end
        SEGTD_OP_FETCH: begin
          if (!is_code) begin
            cause_c = SEGTD_FC_NOT_CODE;
          end else if (lim_fault) begin
            cause_c = SEGTD_FC_LIMIT;
          end
        end
        default: cause_c = SEGTD_FC_NONE;
      endcase
    end
    fault_c = (cause_c != SEGTD_FC_NONE);
  end

  // Accessed-flag write-back
  // A refused request never marks the descriptor as used
  logic wb_c;
  logic abit_on;

  assign abit_on = ctrl_reg[`SEGTD_CTRL_ABIT];
  // Descriptors already marked are left untouched, so ROM tables stay safe
  assign wb_c = is_app & ~fault_c & ~acc_flag &
                (is_load | (abit_on & is_access));

  ////////////////////////////////////////////////////////////////////////
  // Result registers
  // Valid pulses last one cycle; the other results hold until the next request

  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      RES_VALID_O <= 1'b0;
      TYPE_WB_VALID_O <= 1'b0;
    end else begin
      RES_VALID_O <= CHK_VALID_I;
      TYPE_WB_VALID_O <= CHK_VALID_I & wb_c;
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      PROTECTION_FAULT_O <= 1'b0;
      FAULT_CAUSE_O <= SEGTD_FC_NONE;
      SEG_CLASS_O <= SEGTD_CL_DATA;
      SYS_KIND_O <= SEGTD_SK_NONE;
      SYS_INVALID_O <= 1'b0;
      READABLE_O <= 1'b0;
      WRITABLE_O <= 1'b0;
      EXPAND_DOWN_O <= 1'b0;
      CONFORMING_O <= 1'b0;
      NEW_CPL_O <= 2'h0;
      TYPE_WB_O <= 4'h0;
    end else if (CHK_VALID_I) begin
      PROTECTION_FAULT_O <= fault_c;
      FAULT_CAUSE_O <= cause_c;
      SEG_CLASS_O <= cls;
      SYS_KIND_O <= sys_kind;
      SYS_INVALID_O <= sys_bad;
      READABLE_O <= rd_en;
      WRITABLE_O <= wr_en & ~(is_code & prot_on);
      EXPAND_DOWN_O <= exp_down;
      CONFORMING_O <= conf;
      NEW_CPL_O <= fault_c ? CUR_CPL_I : cpl_c;
      TYPE_WB_O <= DESC_TYPE_I | 4'(1 << `SEGTD_T_ACC);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // APB register file

  logic apb_setup;
  logic apb_wr;
  logic hit_ctrl;
  logic hit_stat;
  logic hit_fcnt;
  logic addr_ok;
  logic [`SEGTD_FCNT_W-1:0] fcnt_reg;
  logic [`SEGTD_FCNT_W-1:0] fcnt_next;
  logic [31:0] stat_word;

  assign apb_setup = PSEL_I & ~PENABLE_I;
  assign apb_wr = PSEL_I & PENABLE_I & PWRITE_I;
  assign hit_ctrl = (PADDR_I == `SEGTD_CTRL_OFS);
  assign hit_stat = (PADDR_I == `SEGTD_STAT_OFS);
  assign hit_fcnt = (PADDR_I == `SEGTD_FCNT_OFS);
  assign addr_ok = hit_ctrl | hit_stat | hit_fcnt;
  assign PREADY_O = 1'b1;
  assign PSLVERR_O = PSEL_I & PENABLE_I & ~addr_ok;

  always_comb begin
    stat_word = '0;
    stat_word[`SEGTD_ST_FAULT] = PROTECTION_FAULT_O;
    stat_word[`SEGTD_ST_CAUSE +: 4] = FAULT_CAUSE_O;
    stat_word[`SEGTD_ST_CLASS +: 2] = SEG_CLASS_O;
    stat_word[`SEGTD_ST_SYS +: 4] = SYS_KIND_O;
    stat_word[`SEGTD_ST_CPL +: 2] = NEW_CPL_O;
  end

  // Control register
  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      ctrl_reg <= `SEGTD_CTRL_RST;
    end else if (apb_wr && hit_ctrl) begin
      ctrl_reg <= PWDATA_I[1:0];
    end
  end

  // Fault counter: a fault in the clearing cycle still counts
  always_comb begin
    fcnt_next = fcnt_reg;
    if (apb_wr && hit_fcnt) begin
      fcnt_next = '0;
    end
    if (CHK_VALID_I && fault_c) begin
      fcnt_next = fcnt_next + 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      fcnt_reg <= '0;
    end else begin
      fcnt_reg <= fcnt_next;
    end
  end

  // Read data is captured in the setup cycle
  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      PRDATA_O <= 32'h0;
    end else if (apb_setup) begin
      if (hit_ctrl) begin
        PRDATA_O <= {30'h0, ctrl_reg};
      end else if (hit_stat) begin
        PRDATA_O <= stat_word;
      end else if (hit_fcnt) begin
        PRDATA_O <= {16'h0, fcnt_reg};
      end else begin
        PRDATA_O <= 32'h0;
      end
    end
  end

endmodule

// *** tb/segtd_check_assertions.sv ***
// Purpose: concurrent checks on the segment check block ports
// Assumes: bound to segtd_check, one clock domain
// Notes: enum encodings follow declaration order
`timescale 1ns/10ps
module segtd_check_assertions
  import segtd_pkg::*;
(
  // Clock and reset
  input wire logic CORE_CLK_I,
  input wire logic RST_N_I,
  // Request
  input wire logic CHK_VALID_I,
  input wire segtd_op_t CHK_OP_I,
  input wire logic DESC_CLASS_I,
  input wire logic [3:0] DESC_TYPE_I,
  // Result
  input wire logic RES_VALID_O,
  input wire logic PROTECTION_FAULT_O,
  input wire segtd_class_t SEG_CLASS_O,
  input wire logic SYS_INVALID_O,
  input wire logic WRITABLE_O,
  input wire logic TYPE_WB_VALID_O,
  input wire logic [3:0] TYPE_WB_O
);
  default clocking cb @(posedge CORE_CLK_I);
  endclocking
  default disable iff (!RST_N_I);
  ////////////////////
  wire logic app_req = CHK_VALID_I && DESC_CLASS_I;
  wire logic rsv_type = DESC_TYPE_I inside {4'h0, 4'h8, 4'hA, 4'hD};
  sequence s_taken;
    CHK_VALID_I ##1 RES_VALID_O;
  endsequence
  sequence s_faulted;
    ##1 RES_VALID_O && PROTECTION_FAULT_O;
  endsequence
  chk_result_latency: assert property (CHK_VALID_I |-> s_taken)
    else $error("result pulse missing");
  chk_no_stray: assert property (RES_VALID_O |-> $past(CHK_VALID_I))
    else $error("result without request");
  chk_code_class: assert property (app_req && DESC_TYPE_I[3] |=>
    SEG_CLASS_O == SEGTD_CL_CODE) else $error("code class wrong");
  chk_data_class: assert property (app_req && !DESC_TYPE_I[3] |=>
    SEG_CLASS_O == SEGTD_CL_DATA && WRITABLE_O == $past(DESC_TYPE_I[1]))
    else $error("data decode wrong");
  chk_stack_fault: assert property (app_req && CHK_OP_I == SEGTD_OP_LOAD_STACK &&
    !DESC_TYPE_I[1] |-> s_faulted) else $error("stack load not faulted");
  chk_system_group: assert property (CHK_VALID_I && !DESC_CLASS_I && !rsv_type |=>
    SEG_CLASS_O inside {SEGTD_CL_SYSSEG, SEGTD_CL_GATE} && !SYS_INVALID_O)
    else $error("system class wrong");
  chk_reserved_flag: assert property (CHK_VALID_I && !DESC_CLASS_I && rsv_type |->
    s_faulted ##0 SYS_INVALID_O) else $error("reserved type not flagged");
  chk_wb_when_clear: assert property (TYPE_WB_VALID_O |-> RES_VALID_O &&
    !$past(DESC_TYPE_I[0]) && TYPE_WB_O == ($past(DESC_TYPE_I) | 4'h1))
    else $error("bad type write back");
endmodule

// *** tb/segtd_core_model.sv ***
// Purpose: core-side source of segment check requests
// Assumes: one request at a time, held through its taken edge
// Notes: size and granularity flags come with each request
`timescale 1ns/10ps
module segtd_core_model
  import segtd_pkg::*;
(
  // Clock
  input wire logic clk_i,
  // Check request
  output logic valid_o,
  output segtd_op_t op_o,
  output logic class_o,
  output logic [3:0] type_o,
  output logic [1:0] dpl_o,
  output logic big_o,
  output logic gran_o,
  output logic [19:0] limit_o,
  output logic [31:0] offset_o,
  output logic [1:0] cpl_o,
  output logic gate_o
);
  ////////////////////
  initial begin
    valid_o = 1'b0;
    op_o = SEGTD_OP_LOAD_DATA;
    {class_o, type_o, dpl_o, big_o, gran_o, limit_o, offset_o, cpl_o, gate_o} = '0;
  end
  task automatic send(input segtd_op_t op, input logic c, input logic [3:0] t,
      input logic [1:0] d, input logic [1:0] p, input logic g, input logic b,
      input logic gr, input logic [19:0] l, input logic [31:0] o);
    @(posedge clk_i);
    valid_o <= 1'b1;
    big_o <= b;
    gran_o <= gr;
    op_o <= op;
    class_o <= c;
    type_o <= t;
    dpl_o <= d;
    cpl_o <= p;
    gate_o <= g;
    limit_o <= l;
    offset_o <= o;
    @(posedge clk_i);
    // Released fields must not look like the last request
    valid_o <= 1'b0;
    type_o <= ~t;
    offset_o <= ~o;
  endtask
endmodule

// *** tb/segtd_check_tb.sv ***
// Purpose: self-checking bench for the segment check block
// Assumes: zero-wait APB slave, one-cycle check latency
// Notes: type and class from the loop index, other descriptor fields from an xorshift stream seeded with 6933
`timescale 1ns/10ps
`include "segtd_consts.svh"
module segtd_check_tb
  import segtd_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [11:0] padr = 12'h000;
  logic [31:0] pwd = 32'h00000000;
  logic [31:0] seed = 32'h00001B15;
  logic [31:0] prd, q, st;
  logic prdy, perr, e, cv, cc, big, gran, gate, rv, flt, sinv, rd, wr, ed, cf, wbv, ew;
  logic [1:0] ctrl, dpl, cpl, ncpl, en, ecl;
  logic [3:0] ty, wbt, esk;
  logic [19:0] dl;
  logic [31:0] doff;
  segtd_op_t op;
  segtd_cause_t cause, ec;
  segtd_class_t scl;
  segtd_sys_t sk;
  int errors = 0;
  int check_count = 0;
  int cycles = 0;
  int fcnt = 0;
  logic [3:0] skt [16] = '{4'hD, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7,
    4'hD, 4'h8, 4'hD, 4'h9, 4'hA, 4'hD, 4'hB, 4'hC};
  ////////////////////
  always #4 clk = ~clk;
  segtd_check i_segtd_check (.CORE_CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel),
    .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(padr), .PWDATA_I(pwd), .PRDATA_O(prd),
    .PREADY_O(prdy), .PSLVERR_O(perr), .CHK_VALID_I(cv), .CHK_OP_I(op),
    .DESC_CLASS_I(cc), .DESC_TYPE_I(ty), .DESC_DPL_I(dpl), .DESC_BIG_I(big),
    .DESC_GRAN_I(gran), .DESC_LIMIT_I(dl), .ACC_OFFSET_I(doff), .CUR_CPL_I(cpl),
    .VIA_GATE_I(gate), .RES_VALID_O(rv), .PROTECTION_FAULT_O(flt),
    .FAULT_CAUSE_O(cause), .SEG_CLASS_O(scl), .SYS_KIND_O(sk), .SYS_INVALID_O(sinv),
    .READABLE_O(rd), .WRITABLE_O(wr), .EXPAND_DOWN_O(ed), .CONFORMING_O(cf),
    .NEW_CPL_O(ncpl), .TYPE_WB_VALID_O(wbv), .TYPE_WB_O(wbt));
  segtd_core_model i_core (.clk_i(clk), .valid_o(cv), .op_o(op), .class_o(cc),
    .type_o(ty), .dpl_o(dpl), .big_o(big), .gran_o(gran), .limit_o(dl),
    .offset_o(doff), .cpl_o(cpl), .gate_o(gate));
  ////////////////////
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic give_verdict();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] rq, output logic re);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    padr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (prdy !== 1'b1);
    rq = prd;
    re = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic predict(input segtd_op_t k, input logic c, input logic [3:0] t,
      input logic [1:0] d, input logic [1:0] p, input logic g, input logic b,
      input logic gr, input logic [31:0] l, input logic [31:0] o);
    logic lf;
    logic [31:0] el;
    el = gr ? {l[19:0], 12'hFFF} : l;
    lf = (!t[3] && t[2]) ? (o < el || (!b && o > 32'h0000FFFF)) : o > el;
    ec = SEGTD_FC_NONE;
    en = p;
    ecl = c ? {1'b0, t[3]} : (t inside {4, 5, 6, 7, 12, 14, 15}) ? 2'h3 : 2'h2;
    if (!c) ec = (skt[t] == 4'hD) ? SEGTD_FC_RESERVED : SEGTD_FC_SYS_USE;
    else case (k)
      SEGTD_OP_LOAD_DATA: if (t[3] && !t[1]) ec = SEGTD_FC_EXEC_ONLY;
        else if (!(t[3] && t[2]) && d > p) ec = SEGTD_FC_PRIV;
      SEGTD_OP_LOAD_STACK: if (t[3] || !t[1]) ec = SEGTD_FC_STACK;
        else if (d != p) ec = SEGTD_FC_PRIV;
      SEGTD_OP_XFER_CODE: if (!t[3]) ec = SEGTD_FC_NOT_CODE;
        else if (t[2] ? d > p : d != p && !g) ec = SEGTD_FC_PRIV;
        else if (!t[2]) en = d;
      SEGTD_OP_READ: if (t[3] && !t[1]) ec = SEGTD_FC_EXEC_ONLY;
        else if (lf) ec = SEGTD_FC_LIMIT;
      SEGTD_OP_WRITE: if (t[3] ? ctrl[0] : !t[1]) ec = SEGTD_FC_WRITE;
        else if (lf) ec = SEGTD_FC_LIMIT;
      default: if (!t[3]) ec = SEGTD_FC_NOT_CODE;
        else if (lf) ec = SEGTD_FC_LIMIT;
    endcase
    ew = c && ec == SEGTD_FC_NONE && !t[0] && (k < SEGTD_OP_READ || ctrl[1]);
  endtask
  ////////////////////
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errors++;
      give_verdict();
    end
  end
  initial begin
    logic [31:0] r, o, l;
    logic [3:0] t;
    segtd_op_t k;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, `SEGTD_CTRL_OFS, 32'h0, q, e);
    cmp(q, {30'h0, `SEGTD_CTRL_RST}, "ctrl reset");
    cmp({31'h0, e}, 32'h0, "mapped");
    apb(1'b0, 12'h00C, 32'h0, q, e);
    cmp({31'h0, e}, 32'h1, "unmapped");
    for (int i = 0; i < 256; i++) begin
      if (i % 64 == 0) begin
        ctrl = i[7:6];
        apb(1'b1, `SEGTD_CTRL_OFS, {30'h0, ctrl}, q, e);
      end
      r = rnd();
      t = i[3:0];
      l = {24'h0, r[7:0]};
      o = l + {30'h0, r[9:8]} - 32'h2;
      k = segtd_op_t'(r[31:29] % 3'h6);
      i_core.send(k, i[4], t, r[11:10], r[13:12], r[14], r[15], r[16], l[19:0], o);
      #1;
      predict(k, i[4], t, r[11:10], r[13:12], r[14], r[15], r[16], l, o);
      esk = i[4] ? 4'h0 : skt[t];
      cmp(rv, 32'h1, "valid");
      cmp(cause, ec, "cause");
      cmp(flt, ec != SEGTD_FC_NONE, "fault");
      cmp(ncpl, en, "level");
      cmp(sk, esk, "kind");
      cmp(sinv, !i[4] && esk == 4'hD, "invalid");
      cmp(scl, ecl, "class");
      cmp(wbv, ew, "wb");
      cmp(wbt, t | 4'h1, "wb type");
      cmp(ed, i[4] && !t[3] && t[2], "down");
      cmp(cf, i[4] && t[3] && t[2], "conf");
      cmp(rd, i[4] && (!t[3] || t[1]), "read");
      cmp(wr, i[4] && !t[3] && t[1], "write");
      fcnt += int'(ec != SEGTD_FC_NONE);
      st = {14'h0, en, esk, 2'h0, ecl, ec, 3'h0, ec != SEGTD_FC_NONE};
    end
    apb(1'b0, `SEGTD_FCNT_OFS, 32'h0, q, e);
    cmp(q, fcnt, "count");
    apb(1'b0, `SEGTD_STAT_OFS, 32'h0, q, e);
    cmp(q, st, "status");
    apb(1'b1, `SEGTD_FCNT_OFS, 32'h0, q, e);
    apb(1'b0, `SEGTD_FCNT_OFS, 32'h0, q, e);
    cmp(q, 32'h0, "cleared");
    give_verdict();
  end
endmodule
bind segtd_check segtd_check_assertions i_chk (.CORE_CLK_I(CORE_CLK_I),
  .RST_N_I(RST_N_I), .CHK_VALID_I(CHK_VALID_I), .CHK_OP_I(CHK_OP_I),
  .DESC_CLASS_I(DESC_CLASS_I), .DESC_TYPE_I(DESC_TYPE_I), .RES_VALID_O(RES_VALID_O),
  .PROTECTION_FAULT_O(PROTECTION_FAULT_O), .SEG_CLASS_O(SEG_CLASS_O),
  .SYS_INVALID_O(SYS_INVALID_O), .WRITABLE_O(WRITABLE_O),
  .TYPE_WB_VALID_O(TYPE_WB_VALID_O), .TYPE_WB_O(TYPE_WB_O));
